// File: bmmc_pkg.sv
// shared constants and types for the memory command decoder and its bus master
`default_nettype none
package bmmc_pkg;
	// ---------------------------------------------------------------
	// command bytes
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_READ_SCRATCHPAD_CMD  = 8'hbe; // read_scratchpad_cmd
	localparam logic [7:0] CMD_WRITE_SCRATCHPAD_CMD = 8'h4e; // write_scratchpad_cmd
	localparam logic [7:0] CMD_COPY_SCRATCHPAD_CMD  = 8'h48; // copy_scratchpad_cmd
	localparam logic [7:0] CMD_RECALL   = 8'hb8;
	localparam logic [7:0] CMD_CONV_T   = 8'h44;
	localparam logic [7:0] CMD_CONV_V   = 8'hb4;
	// ---------------------------------------------------------------
	// page layout
	// ---------------------------------------------------------------
	localparam logic [7:0] PAGE_MAX     = 8'h07;
	localparam int         PAGES        = 8;
	localparam int         PAGE_BYTES   = 8;
	localparam int         MEM_BYTES    = PAGES * PAGE_BYTES;
	localparam logic [3:0] CRC_IDX      = 4'h8;
	localparam logic [3:0] END_IDX      = 4'h9;
	localparam logic [7:0] ALL_ONES     = 8'hff;
	localparam logic [7:0] BUSY_BYTE    = 8'h00;
	localparam logic [7:0] CRC_POLY     = 8'h8c; // reflected x^8+x^5+x^4+1
	localparam logic [7:0] CRC_INIT     = 8'h00;
	// page 0 byte positions: configuration, temperature, voltage
	localparam int         CFG_BYTE     = 0;
	localparam int         CFG_AD_BIT   = 3;
	localparam int         TEMP_LO      = 1;
	localparam int         VOLT_LO      = 3;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam longint     CLK_HZ       = 100_000_000;
	localparam longint     NV_WRITE_MS  = 50;
	localparam longint     CONV_T_MS    = 1000;
	localparam longint     CONV_V_MS    = 2;
	// all three times round down to whole cycles
	localparam int unsigned NV_CYC = 32'((NV_WRITE_MS * CLK_HZ) / 1000);
	localparam int unsigned T_CYC  = 32'((CONV_T_MS * CLK_HZ) / 1000);
	localparam int unsigned V_CYC  = 32'((CONV_V_MS * CLK_HZ) / 1000);
	// ---------------------------------------------------------------
	// host request kinds
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {OP_RESET, OP_WRITE, OP_READ} bmmc_op_t;
endpackage
`default_nettype wire

// File: bmmc_if.sv
// byte-level link between the bus master and the memory command decoder
`timescale 1ns/1ps
`default_nettype none
interface bmmc_if;
	logic       rst_pulse; // bus reset, one cycle
	logic       wr_valid;  // master byte, one cycle
	logic [7:0] wr_byte;
	logic       rd_req;    // master read of eight slots, one cycle
	logic       rd_valid;  // device answer, one cycle
	logic [7:0] rd_byte;
	logic       drive;     // device is driving data or busy slots

	modport dev (input rst_pulse, wr_valid, wr_byte, rd_req,
		output rd_valid, rd_byte, drive);
	modport mst (output rst_pulse, wr_valid, wr_byte, rd_req,
		input rd_valid, rd_byte, drive);
endinterface
`default_nettype wire

// File: bmmc_host.sv
// bus master end: turns user reset, write and read requests into link events
`timescale 1ns/1ps
`default_nettype none
module bmmc_host
	import bmmc_pkg::*;
(
	input  wire logic            CLK,
	input  wire logic            RST_N,
	bmmc_if.mst                  bus,
	input  wire logic            USR_VALID,
	input  wire bmmc_pkg::bmmc_op_t USR_OP,
	input  wire logic [7:0]      USR_DATA,
	output logic                 USR_READY,
	output logic                 USR_REFUSED,
	output logic                 RSP_VALID,
	output logic [7:0]           RSP_DATA
);
	import bmmc_pkg::*;

	logic       wait_q;     // read outstanding
	logic       first_q;    // next byte is a command
	logic       page_nx_q;  // next byte is a page number
	logic       take;
	logic       bad_page;

	assign USR_READY = !wait_q;
	assign take      = USR_VALID && !wait_q;
	// page numbers above seven are never sent
	assign bad_page  = page_nx_q && (USR_DATA > PAGE_MAX); // RULE4

	// ---------------------------------------------------------------
	// link event pulses
	// ---------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			bus.rst_pulse <= 1'b0;
			bus.wr_valid  <= 1'b0;
			bus.wr_byte   <= 8'h00;
			bus.rd_req    <= 1'b0;
			USR_REFUSED   <= 1'b0;
		end else begin
			bus.rst_pulse <= take && USR_OP == OP_RESET; // RULE3
			bus.wr_valid  <= take && USR_OP == OP_WRITE && !bad_page;
			bus.rd_req    <= take && USR_OP == OP_READ;
			USR_REFUSED   <= take && USR_OP == OP_WRITE && bad_page;
			if (take && USR_OP == OP_WRITE)
				bus.wr_byte <= USR_DATA;
		end
	end

	// ---------------------------------------------------------------
	// command tracking
	// ---------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			first_q   <= 1'b1;
			page_nx_q <= 1'b0;
		end else if (take && USR_OP == OP_RESET) begin
			first_q   <= 1'b1;
			page_nx_q <= 1'b0;
		end else if (take && USR_OP == OP_WRITE && !bad_page) begin
			first_q   <= 1'b0;
			page_nx_q <= first_q && (USR_DATA == CMD_READ_SCRATCHPAD_CMD || USR_DATA == CMD_WRITE_SCRATCHPAD_CMD
				|| USR_DATA == CMD_COPY_SCRATCHPAD_CMD || USR_DATA == CMD_RECALL); // RULE1 RULE5
		end
	end

	// ---------------------------------------------------------------
	// read answer; busy polls return 00 until done (RULE7)
	// ---------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			wait_q    <= 1'b0;
			RSP_VALID <= 1'b0;
			RSP_DATA  <= 8'h00;
		end else begin
			RSP_VALID <= wait_q && bus.rd_valid;
			if (take && USR_OP == OP_READ)
				wait_q <= 1'b1;
			else if (bus.rd_valid)
				wait_q <= 1'b0;
			if (wait_q && bus.rd_valid)
				RSP_DATA <= bus.rd_byte; // RULE9
		end
	end
endmodule
`default_nettype wire

// File: bmmc_dev.sv
// device end: memory and conversion command decoder with scratchpad and memory pages
//
// Behaviour
// [RULE1] read command plus page streams page from 0
// [RULE2] reserved bits and bytes past end read ones
// [RULE3] bus reset aborts read, stops driving
// [RULE4] master sends only pages zero to seven
// [RULE5] copy moves scratchpad page into memory
// [RULE6] slots read 0 while copy busy
// [RULE7] memory write completes within 50 ms
// [RULE8] recall loads memory page into scratchpad, idle
// [RULE9] master recalls before reading memory contents
// [RULE10] temperature command alone starts conversion
// [RULE11] temperature busy slots 0, flag set meanwhile
// [RULE12] temperature conversion ends within one second
// [RULE13] voltage command converts input chosen by config
// [RULE14] voltage busy flag; result into page zero
// [RULE15] other commands keep working during voltage conversion
// [RULE16] slots read 0 during voltage conversion
// [RULE17] voltage conversion ends within 2 ms
// [RULE18] full read gives eight bytes plus CRC
// [RULE19] write command stores bytes from 0, reset ends
// [RULE20] bad page ignored until next bus reset
// [RULE21] nothing pending means slots read 1
`timescale 1ns/1ps
`default_nettype none
module bmmc_dev
	import bmmc_pkg::*;
#(
	parameter int unsigned NV_CYCLES = NV_CYC,
	parameter int unsigned T_CYCLES  = T_CYC,
	parameter int unsigned V_CYCLES  = V_CYC,
	parameter logic [8*MEM_BYTES-1:0] RSV_MASK = '0 // one bit per scratch bit, 1 = reserved
)
(
	input  wire logic        CLK,
	input  wire logic        RST_N,
	bmmc_if.dev              bus,
	input  wire logic [15:0] TEMP_IN,
	input  wire logic [15:0] VOLT_A_IN,
	input  wire logic [15:0] VOLT_B_IN,
	output logic             ADC_SEL,
	output logic             TEMPERATURE_BUSY_FLAG,
	output logic             ADC_BUSY_FLAG,
	output logic             NONVOLATILE_BUSY_FLAG
);
	import bmmc_pkg::*;

	// ---------------------------------------------------------------
	// parameter checks
	// ---------------------------------------------------------------
	if (NV_CYCLES < 1 || T_CYCLES < 1 || V_CYCLES < 1)
		$error("busy cycle counts must be at least one");

	typedef enum logic [2:0] {S_IDLE, S_PAGE, S_READ, S_WRITE, S_POLL, S_IGNORE} bmmc_st_t;
	typedef enum logic [1:0] {P_NONE, P_NV, P_T, P_V} bmmc_poll_t;

	bmmc_st_t    state_q;
	bmmc_poll_t  poll_q;
	logic [7:0]  cmd_q;
	logic [2:0]  page_q;
	logic [3:0]  idx_q;
	logic [7:0]  crc_q;
	logic [31:0] nv_cnt_q;
	logic [31:0] t_cnt_q;
	logic [31:0] v_cnt_q;
	logic [7:0]  scratch [MEM_BYTES];
	logic [7:0]  mem     [MEM_BYTES];
	logic [5:0]  base;
	logic [7:0]  rd_data;
	logic        poll_busy;
	logic        page_ok;
	logic        start_t;
	logic        start_v;
	logic        start_cp;

	assign base    = {page_q, 3'h0};
	assign page_ok = bus.wr_valid && bus.wr_byte <= PAGE_MAX;
	assign start_t = state_q == S_IDLE && bus.wr_valid && bus.wr_byte == CMD_CONV_T;
	assign start_v = state_q == S_IDLE && bus.wr_valid && bus.wr_byte == CMD_CONV_V;
	assign start_cp = state_q == S_PAGE && page_ok && cmd_q == CMD_COPY_SCRATCHPAD_CMD;

	assign TEMPERATURE_BUSY_FLAG = t_cnt_q != 32'h0; // RULE11
	assign ADC_BUSY_FLAG         = v_cnt_q != 32'h0; // RULE14
	assign NONVOLATILE_BUSY_FLAG = nv_cnt_q != 32'h0;

	// one CRC step over a byte, least significant bit first
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		return r;
	endfunction

	// ---------------------------------------------------------------
	// command sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_q <= S_IDLE;
			poll_q  <= P_NONE;
			cmd_q   <= 8'h00;
			page_q  <= 3'h0;
			idx_q   <= 4'h0;
			crc_q   <= CRC_INIT;
		end else if (bus.rst_pulse) begin
			state_q <= S_IDLE; // RULE3 RULE19
		end else begin
			unique case (state_q)
				S_IDLE: if (bus.wr_valid) begin
					cmd_q <= bus.wr_byte;
					if (bus.wr_byte == CMD_READ_SCRATCHPAD_CMD || bus.wr_byte == CMD_WRITE_SCRATCHPAD_CMD ||
						bus.wr_byte == CMD_COPY_SCRATCHPAD_CMD || bus.wr_byte == CMD_RECALL)
						state_q <= S_PAGE;
					else if (bus.wr_byte == CMD_CONV_T) begin
						state_q <= S_POLL; // RULE10
						poll_q  <= P_T;
					end else if (bus.wr_byte == CMD_CONV_V) begin
						state_q <= S_POLL;
						poll_q  <= P_V;
					end else
						state_q <= S_IGNORE;
				end
				S_PAGE: if (bus.wr_valid) begin
					page_q <= bus.wr_byte[2:0];
					idx_q  <= 4'h0;
					crc_q  <= CRC_INIT;
					if (!page_ok)
						state_q <= S_IGNORE; // RULE20
					else if (cmd_q == CMD_READ_SCRATCHPAD_CMD)
						state_q <= S_READ; // RULE1
					else if (cmd_q == CMD_WRITE_SCRATCHPAD_CMD)
						state_q <= S_WRITE; // RULE19
					else begin
						state_q <= S_POLL;
						poll_q  <= cmd_q == CMD_COPY_SCRATCHPAD_CMD ? P_NV : P_NONE; // RULE6 RULE8
					end
				end
				S_READ: if (bus.rd_req && idx_q != END_IDX) begin
					idx_q <= idx_q + 4'h1;
					if (idx_q < CRC_IDX)
						crc_q <= crc8(crc_q, rd_data); // RULE18
				end
				S_WRITE: if (bus.wr_valid && idx_q < CRC_IDX)
					idx_q <= idx_q + 4'h1;
				S_POLL, S_IGNORE: ;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// scratchpad: master writes and recall
	// ---------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (state_q == S_WRITE && bus.wr_valid && !bus.rst_pulse && idx_q < CRC_IDX)
			scratch[base + {3'h0, idx_q[2:0]}] <= bus.wr_byte; // RULE19
		if (state_q == S_PAGE && !bus.rst_pulse && page_ok && cmd_q == CMD_RECALL)
			for (int i = 0; i < PAGE_BYTES; i++)
				scratch[{bus.wr_byte[2:0], 3'(i)}] <= mem[{bus.wr_byte[2:0], 3'(i)}]; // RULE8
	end

	// ---------------------------------------------------------------
	// memory pages: copy and conversion results
	// ---------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (start_cp && !bus.rst_pulse)
			for (int i = 0; i < PAGE_BYTES; i++)
				mem[{bus.wr_byte[2:0], 3'(i)}] <= scratch[{bus.wr_byte[2:0], 3'(i)}]; // RULE5
		if (t_cnt_q == 32'h1) begin
			mem[TEMP_LO]     <= TEMP_IN[7:0];
			mem[TEMP_LO + 1] <= TEMP_IN[15:8];
		end
		if (v_cnt_q == 32'h1) begin
			mem[VOLT_LO]     <= ADC_SEL ? VOLT_B_IN[7:0] : VOLT_A_IN[7:0]; // RULE14
			mem[VOLT_LO + 1] <= ADC_SEL ? VOLT_B_IN[15:8] : VOLT_A_IN[15:8];
		end
	end

	// ---------------------------------------------------------------
	// busy timers, free of the sequencer so commands go on (RULE15)
	// ---------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			nv_cnt_q <= 32'h0;
			t_cnt_q  <= 32'h0;
			v_cnt_q  <= 32'h0;
			ADC_SEL  <= 1'b0;
		end else begin
			if (start_cp && !bus.rst_pulse)
				nv_cnt_q <= NV_CYCLES; // RULE7
			else if (nv_cnt_q != 32'h0)
				nv_cnt_q <= nv_cnt_q - 32'h1;
			if (start_t && !bus.rst_pulse)
				t_cnt_q <= T_CYCLES; // RULE12
			else if (t_cnt_q != 32'h0)
				t_cnt_q <= t_cnt_q - 32'h1;
			if (start_v && !bus.rst_pulse) begin
				v_cnt_q <= V_CYCLES; // RULE17
				ADC_SEL <= mem[CFG_BYTE][CFG_AD_BIT]; // RULE13
			end else if (v_cnt_q != 32'h0)
				v_cnt_q <= v_cnt_q - 32'h1;
		end
	end

	// ---------------------------------------------------------------
	// read slot answers
	// ---------------------------------------------------------------
	always_comb begin
		unique case (poll_q)
			P_NV:    poll_busy = NONVOLATILE_BUSY_FLAG; // RULE6
			P_T:     poll_busy = TEMPERATURE_BUSY_FLAG; // RULE11
			P_V:     poll_busy = ADC_BUSY_FLAG; // RULE16
			default: poll_busy = 1'b0; // RULE21
		endcase
		rd_data = ALL_ONES;
		if (state_q == S_READ) begin
			if (idx_q < CRC_IDX)
				rd_data = scratch[base + {3'h0, idx_q[2:0]}]
					| RSV_MASK[{base + {3'h0, idx_q[2:0]}, 3'h0} +: 8]; // RULE2
			else if (idx_q == CRC_IDX)
				rd_data = crc_q; // RULE18
		end else if (state_q == S_POLL)
			rd_data = poll_busy ? BUSY_BYTE : ALL_ONES;
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			bus.rd_valid <= 1'b0;
			bus.rd_byte  <= ALL_ONES;
		end else begin
			bus.rd_valid <= bus.rd_req && !bus.rst_pulse;
			if (bus.rd_req)
				bus.rd_byte <= rd_data;
		end
	end

	assign bus.drive = state_q == S_READ || state_q == S_POLL; // RULE3 RULE20
endmodule
`default_nettype wire

// File: bmmc_monitor.sv
// link checker for the bus master and memory command decoder
`timescale 1ns/1ps
`default_nettype none
module bmmc_monitor (
	input wire logic       CLK,
	input wire logic       RST_N,
	input wire logic       rst_pulse,
	input wire logic       wr_valid,
	input wire logic [7:0] wr_byte,
	input wire logic       rd_req,
	input wire logic       rd_valid,
	input wire logic [7:0] rd_byte,
	input wire logic       drive
);
	import bmmc_pkg::*;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic       first_q; // next byte is a command
	logic       page_q;  // this byte is a page number
	logic [7:0] cmd_q;
	// ------------------------------------------------------------
	// command and page byte tracking
	// ------------------------------------------------------------
	// bus reset makes the next byte a command again
	always_ff @(posedge CLK) begin
		if (!RST_N || rst_pulse) begin
			first_q <= 1'b1;
			page_q  <= 1'b0;
		end else if (wr_valid) begin
			first_q <= 1'b0;
			page_q  <= first_q && (wr_byte inside {CMD_READ_SCRATCHPAD_CMD, CMD_WRITE_SCRATCHPAD_CMD,
				CMD_COPY_SCRATCHPAD_CMD, CMD_RECALL});
		end
	end
	// keep the last command byte
	always_ff @(posedge CLK) begin
		if (wr_valid && first_q) begin
			cmd_q <= wr_byte;
		end
	end
	sequence s_page(c);
		wr_valid && page_q && cmd_q == c;
	endsequence
	sequence s_cmd(c);
		wr_valid && first_q && wr_byte == c;
	endsequence
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	answer_next_a: assert property (rd_req && !rst_pulse |=> rd_valid)
		else $error("read not answered next cycle");
	answer_cause_a: assert property (rd_valid |-> $past(rd_req))
		else $error("answer without a read");
	abort_release_a: assert property (rst_pulse |=> !drive && !rd_valid)
		else $error("still driving after bus reset");
	idle_ones_a: assert property (rst_pulse ##1 rd_req |=> rd_byte == ALL_ONES)
		else $error("idle read not all ones");
	page_range_a: assert property (wr_valid && page_q |-> wr_byte <= PAGE_MAX)
		else $error("page number out of range");
	read_drives_a: assert property (s_page(CMD_READ_SCRATCHPAD_CMD) |=> drive)
		else $error("read command not driving");
	copy_busy_a: assert property (s_page(CMD_COPY_SCRATCHPAD_CMD) ##1 rd_req |=> rd_byte == BUSY_BYTE)
		else $error("copy slot not busy");
	temp_busy_a: assert property (s_cmd(CMD_CONV_T) ##1 rd_req |=> rd_byte == BUSY_BYTE)
		else $error("temperature slot not busy");
	volt_busy_a: assert property (s_cmd(CMD_CONV_V) ##1 rd_req |=> rd_byte == BUSY_BYTE)
		else $error("voltage slot not busy");
	recall_idle_a: assert property (s_page(CMD_RECALL) ##1 rd_req |=> rd_byte == ALL_ONES)
		else $error("recall slot not idle");
endmodule
`default_nettype wire

// File: battery_monitor_memory_commands_tb_top.sv
// self-checking bench for the memory command decoder and its bus master
`timescale 1ns/1ps
`default_nettype none
module battery_monitor_memory_commands_tb_top;
	import bmmc_pkg::*;
	logic       CLK = 1'b0;
	logic       RST_N = 1'b0;
	logic       usr_valid = 1'b0;
	bmmc_op_t   usr_op = OP_RESET;
	logic [7:0] usr_data = 8'h00;
	logic [15:0] temp_in   = 16'h1234;
	logic [15:0] volt_a_in = 16'h0a0b;
	logic [15:0] volt_b_in = 16'h0c0d;
	logic       usr_ready, usr_refused, rsp_valid, adc_sel, t_busy, v_busy, nv_busy;
	logic [7:0] rsp_data;
	logic       refused_seen = 1'b0;
	int         miscompares = 0;
	int         cmp_count = 0;
	int         cycles = 0;
	wire  [2:0] busy = {nv_busy, v_busy, t_busy};
	bmmc_if bus_if ();
	// ------------------------------------------------------------
	// clock, instances
	// ------------------------------------------------------------
	always #5 CLK = ~CLK;
	bmmc_host bmmc_host_i (.CLK(CLK), .RST_N(RST_N), .bus(bus_if), .USR_VALID(usr_valid),
		.USR_OP(usr_op), .USR_DATA(usr_data), .USR_READY(usr_ready),
		.USR_REFUSED(usr_refused), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
	// bit 7 of scratch page 5 byte 0 is marked reserved
	bmmc_dev #(.NV_CYCLES(20), .T_CYCLES(30), .V_CYCLES(10), .RSV_MASK(512'h1 << 327))
		bmmc_dev_i (.CLK(CLK),
		.RST_N(RST_N), .bus(bus_if), .TEMP_IN(temp_in), .VOLT_A_IN(volt_a_in),
		.VOLT_B_IN(volt_b_in), .ADC_SEL(adc_sel), .TEMPERATURE_BUSY_FLAG(t_busy),
		.ADC_BUSY_FLAG(v_busy), .NONVOLATILE_BUSY_FLAG(nv_busy));
	bmmc_monitor bmmc_monitor_i (.CLK(CLK), .RST_N(RST_N), .rst_pulse(bus_if.rst_pulse),
		.wr_valid(bus_if.wr_valid), .wr_byte(bus_if.wr_byte), .rd_req(bus_if.rd_req),
		.rd_valid(bus_if.rd_valid), .rd_byte(bus_if.rd_byte), .drive(bus_if.drive));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(string w, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
		end
	endtask
	// request stays up; the take happens at the next rising edge
	task automatic op(bmmc_op_t o, logic [7:0] d);
		@(negedge CLK);
		usr_valid = 1'b1;
		usr_op = o;
		usr_data = d;
		while (usr_ready !== 1'b1) @(negedge CLK);
	endtask
	task automatic idle(int n);
		@(negedge CLK);
		usr_valid = 1'b0;
		repeat (n) @(negedge CLK);
	endtask
	task automatic rd(output logic [7:0] v);
		op(OP_READ, 8'h00);
		@(negedge CLK);
		usr_valid = 1'b0;
		for (int i = 0; i < 8 && rsp_valid !== 1'b1; i++) @(negedge CLK);
		v = rsp_data;
	endtask
	task automatic rdc(string w, logic [7:0] e);
		logic [7:0] v;
		rd(v);
		chk(w, e, v);
	endtask
	// bus reset, command byte, optional page byte
	task automatic cmd(logic [7:0] c, logic [7:0] p, bit has_p);
		op(OP_RESET, 8'h00);
		op(OP_WRITE, c);
		if (has_p) op(OP_WRITE, p);
	endtask
	// slots read 0 while busy, then 1 within lim reads
	task automatic poll(string w, int lim, int f);
		logic [7:0] v;
		int n = 0;
		rd(v);
		chk(w, BUSY_BYTE, v);
		chk(w, 8'h01, {7'h00, busy[f]});
		while (v !== ALL_ONES && n < lim) begin
			rd(v);
			n++;
		end
		chk(w, ALL_ONES, v);
		chk(w, 8'h00, {7'h00, busy[f]});
	endtask
	function automatic logic [7:0] crc_step(logic [7:0] c, logic [7:0] b);
		c = c ^ b;
		for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		return c;
	endfunction
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic s_write_read();
		logic [7:0] crc = CRC_INIT;
		cmd(CMD_WRITE_SCRATCHPAD_CMD, 8'h02, 1);
		for (int i = 0; i < 8; i++) op(OP_WRITE, 8'h30 + 8'(i));
		op(OP_WRITE, 8'h55); // ninth byte must be dropped
		cmd(CMD_READ_SCRATCHPAD_CMD, 8'h02, 1);
		for (int i = 0; i < 8; i++) begin
			rdc("scratch", 8'h30 + 8'(i));
			crc = crc_step(crc, 8'h30 + 8'(i));
		end
		rdc("crc", crc);
		rdc("past end", ALL_ONES);
	endtask
	task automatic s_copy_recall();
		cmd(CMD_COPY_SCRATCHPAD_CMD, 8'h02, 1);
		poll("copy", 6, 2);
		cmd(CMD_WRITE_SCRATCHPAD_CMD, 8'h02, 1);
		op(OP_WRITE, 8'haa);
		cmd(CMD_RECALL, 8'h02, 1);
		rdc("recall", ALL_ONES);
		cmd(CMD_READ_SCRATCHPAD_CMD, 8'h02, 1);
		rdc("recalled", 8'h30);
		rdc("recalled", 8'h31);
		chk("drive", 8'h01, {7'h00, bus_if.drive});
		op(OP_RESET, 8'h00);
		rdc("aborted", ALL_ONES);
		chk("drive", 8'h00, {7'h00, bus_if.drive});
	endtask
	task automatic s_conv();
		cmd(CMD_WRITE_SCRATCHPAD_CMD, 8'h00, 1);
		op(OP_WRITE, 8'h08); // select the second voltage input
		cmd(CMD_COPY_SCRATCHPAD_CMD, 8'h00, 1);
		poll("copy", 6, 2);
		cmd(CMD_CONV_T, 8'h00, 0);
		poll("temp", 8, 0);
		cmd(CMD_CONV_V, 8'h00, 0);
		poll("volt", 4, 1);
		chk("adc sel", 8'h01, {7'h00, adc_sel});
		cmd(CMD_CONV_V, 8'h00, 0);
		cmd(CMD_WRITE_SCRATCHPAD_CMD, 8'h05, 1);
		op(OP_WRITE, 8'h77);
		cmd(CMD_READ_SCRATCHPAD_CMD, 8'h05, 1);
		rdc("during conv", 8'h77 | 8'h80);
		cmd(CMD_RECALL, 8'h00, 1);
		cmd(CMD_READ_SCRATCHPAD_CMD, 8'h00, 1);
		rdc("config", 8'h08);
		rdc("temp lo", temp_in[7:0]);
		rdc("temp hi", temp_in[15:8]);
		rdc("volt lo", volt_b_in[7:0]);
		rdc("volt hi", volt_b_in[15:8]);
	endtask
	task automatic s_bad_page();
		cmd(CMD_READ_SCRATCHPAD_CMD, 8'h09, 1);
		idle(3);
		chk("refused", 8'h01, {7'h00, refused_seen});
		rdc("bad page", ALL_ONES);
		chk("drive", 8'h00, {7'h00, bus_if.drive});
	endtask
	// ------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------
	always @(posedge CLK) begin
		if (usr_refused === 1'b1) refused_seen <= 1'b1;
	end
	initial begin
		repeat (3) @(posedge CLK);
		@(negedge CLK);
		RST_N = 1'b1;
		s_write_read();
		s_copy_recall();
		s_conv();
		s_bad_page();
		idle(2);
		give_verdict();
	end
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			give_verdict();
		end
	end
endmodule
`default_nettype wire
